// ===== design/ocf_fault_resp.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Overcurrent sets none-of-above and IOUT OC, IOUT word bit, IOUT overcurrent bit.
// RULE2: Every overcurrent setting sets its fault bit and drives alert unless masked.
// RULE3: Mode 00 limits current and keeps running; mode 01 is refused.
// RULE4: Mode 10 limits for the delay, then follows the retry field if still limiting.
// RULE5: Mode 11 shuts the output at once, then follows the retry field.
// RULE6: Retry 000 keeps output off until run is cycled or power removed.
// RULE7: Retry 111 restarts endlessly after the retry interval until commanded off.
// RULE8: Delay field counts 16 ms units, used only by the delayed mode.
// RULE9: Overcurrent bit clears on clear, off-on, restore, soft reset or power cycle.
// RULE10: Overtemperature action is an unpaged byte at 0xD6, default 0xC0.
// RULE11: Overtemperature sets none-of-above, MFR word bit, MFR overtemp bit, alert.
// RULE12: Overtemperature modes 00 and 01 raise a CML fault on write.
// RULE13: Overtemperature mode 10 disables the output at once and stays off.
// RULE14: Overtemperature mode 11 holds output off only while the condition lasts.
// RULE15: Overtemperature retry other than 000 raises a CML fault on write.
// RULE16: Overtemperature delay bits are ignored.
// RULE17: Overtemperature bit clears on clear, off-on, or power cycle only.
// RULE18: Overcurrent action is a paged read/write byte at 0x47, default 0x00.
// RULE19: Each channel keeps its own overcurrent settings and timing.
module ocf_fault_resp
  import ocf_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES,
  parameter int RETRY_TICKS = RETRY_TIME_MS
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_write_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [7:0]  cmd_data_in,
  input  wire logic [1:0]  run_in,
  input  wire logic [1:0]  oc_detect_in,
  input  wire logic        ot_detect_in,
  output logic             rd_valid_out,
  output logic [15:0]      rd_data_out,
  output logic [1:0]       output_enable_out,
  output logic [1:0]       current_limit_out,
  output logic             alert_n_out
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [1:0] run_s;
  logic [1:0] oc_s;
  logic       ot_s;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else begin
      pin_s1_r <= {ot_detect_in, oc_detect_in, run_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign run_s = pin_s2_r[1:0];
  assign oc_s  = pin_s2_r[3:2];
  assign ot_s  = pin_s2_r[4];

  // ------------------------------------------------------------
  // Millisecond tick divider
  // ------------------------------------------------------------
  logic [31:0] div_r;
  logic [31:0] div_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = div_r + 32'h0000_0001;
    if (div_r >= 32'(TICK_PERIOD - 1)) begin
      div_nxt  = 32'h0000_0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      div_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ------------------------------------------------------------
  // Configuration and fault state
  // ------------------------------------------------------------
  logic       page_r;
  logic       page_nxt;
  logic [1:0] op_on_r;
  logic [1:0] op_on_nxt;
  logic [7:0] oc_action_r [2];
  logic [7:0] oc_action_nxt [2];
  logic [7:0] ot_action_r;
  logic [7:0] ot_action_nxt;
  logic [3:0] mask_r;
  logic [3:0] mask_nxt;
  logic [1:0] oc_flt_r;
  logic [1:0] oc_flt_nxt;
  logic       ot_flt_r;
  logic       ot_flt_nxt;
  logic       cml_r;
  logic       cml_nxt;
  logic       ot_latch_r;
  logic       ot_latch_nxt;
  logic [1:0] en_prev_r;
  logic [1:0] en_raw;
  logic [1:0] on_rise;
  logic [1:0] chan_en;
  logic [1:0] chan_on;
  logic [1:0] chan_lim;
  logic [1:0] chan_evt;
  logic       wr;
  logic       clr_faults;
  logic       clr_all;
  logic       ot_block;
  logic       cml_bad;
  logic [1:0] ot_mode;

  assign wr         = cmd_valid_in && cmd_write_in;
  assign clr_faults = wr && (cmd_code_in == CMD_CLEAR_FAULTS);
  assign clr_all    = clr_faults || (wr && ((cmd_code_in == CMD_RESTORE_ALL) ||
                                            (cmd_code_in == CMD_SOFT_RESET)));
  assign en_raw     = run_s & op_on_r;
  assign on_rise    = en_raw & ~en_prev_r;
  assign ot_mode    = ot_action_r[RESP_MSB:RESP_LSB]; // RULE16
  assign ot_block   = ot_latch_r || ((ot_mode == OT_RESP_AUTO) && ot_s); // RULE14
  assign chan_en    = ot_block ? 2'b00 : en_raw; // RULE13

  always_comb begin
    page_nxt         = page_r;
    op_on_nxt        = op_on_r;
    oc_action_nxt[0] = oc_action_r[0];
    oc_action_nxt[1] = oc_action_r[1];
    ot_action_nxt    = ot_action_r;
    mask_nxt         = mask_r;
    cml_bad          = 1'b0;
    if (wr) begin
      case (cmd_code_in)
        CMD_PAGE: begin
          page_nxt = cmd_data_in[0];
        end
        CMD_OPERATION: begin
          op_on_nxt[page_r] = cmd_data_in[OP_ON];
        end
        CMD_OC_ACTION: begin
          if (cmd_data_in[RESP_MSB:RESP_LSB] == RESP_BAD) begin
            cml_bad = 1'b1; // RULE3
          end else begin
            oc_action_nxt[page_r] = cmd_data_in; // RULE18 RULE19
          end
        end
        CMD_OT_ACTION: begin
          if ((cmd_data_in[RESP_MSB] == 1'b0) ||
              (cmd_data_in[RETRY_MSB:RETRY_LSB] != RETRY_NONE)) begin
            cml_bad = 1'b1; // RULE12 RULE15
          end else begin
            ot_action_nxt = cmd_data_in; // RULE10
          end
        end
        CMD_ALERT_MASK: begin
          mask_nxt = cmd_data_in[3:0];
        end
        default: begin
          page_nxt = page_r;
        end
      endcase
    end
  end

  // Set wins over every clear source
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      oc_flt_nxt[i] = chan_evt[i] || (oc_flt_r[i] && !(clr_all || on_rise[i])); // RULE1 RULE2 RULE9
    end
    ot_flt_nxt   = ot_s || (ot_flt_r && !(clr_faults || (|on_rise))); // RULE11 RULE17
    ot_latch_nxt = (ot_s && (ot_mode == OT_RESP_LAT)) ||
                   (ot_latch_r && !(clr_faults || (|on_rise))); // RULE13 RULE17
    cml_nxt      = cml_bad || (cml_r && !clr_all);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      page_r         <= 1'b0;
      op_on_r        <= {2{OPERATION_RST}};
      oc_action_r[0] <= OC_ACTION_RST;
      oc_action_r[1] <= OC_ACTION_RST;
      ot_action_r    <= OT_ACTION_RST;
      mask_r         <= ALERT_MASK_RST;
      oc_flt_r       <= 2'b00;
      ot_flt_r       <= 1'b0;
      cml_r          <= 1'b0;
      ot_latch_r     <= 1'b0;
      en_prev_r      <= 2'b00;
    end else begin
      page_r         <= page_nxt;
      op_on_r        <= op_on_nxt;
      oc_action_r[0] <= oc_action_nxt[0];
      oc_action_r[1] <= oc_action_nxt[1];
      ot_action_r    <= ot_action_nxt;
      mask_r         <= mask_nxt;
      oc_flt_r       <= oc_flt_nxt;
      ot_flt_r       <= ot_flt_nxt;
      cml_r          <= cml_nxt;
      ot_latch_r     <= ot_latch_nxt;
      en_prev_r      <= en_raw;
    end
  end

  // ------------------------------------------------------------
  // Channel sequencers
  // ------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_chan
    ocf_chan #(
      .RETRY_TICKS (RETRY_TICKS)
    ) u_chan (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .tick_in       (tick_r),
      .enable_in     (chan_en[g]),
      .oc_det_in     (oc_s[g]),
      .action_in     (oc_action_r[g]),
      .output_on_out (chan_on[g]),
      .limiting_out  (chan_lim[g]),
      .oc_event_out  (chan_evt[g])
    );
  end

  // ------------------------------------------------------------
  // Read answers and outputs
  // ------------------------------------------------------------
  logic        rd_valid_nxt;
  logic [15:0] rd_data_nxt;
  logic [1:0]  out_en_nxt;
  logic        alert_n_nxt;
  logic [7:0]  stat_byte;

  always_comb begin
    stat_byte             = 8'h00;
    stat_byte[SB_NONE]    = oc_flt_r[page_r] || ot_flt_r; // RULE1 RULE11
    stat_byte[SB_CML]     = cml_r;
    stat_byte[SB_IOUT_OC] = oc_flt_r[page_r]; // RULE1
    rd_valid_nxt          = cmd_valid_in && !cmd_write_in;
    rd_data_nxt           = 16'h0000;
    case (cmd_code_in)
      CMD_PAGE:        rd_data_nxt[0] = page_r;
      CMD_OPERATION:   rd_data_nxt[OP_ON] = op_on_r[page_r];
      CMD_OC_ACTION:   rd_data_nxt[7:0] = oc_action_r[page_r];
      CMD_OT_ACTION:   rd_data_nxt[7:0] = ot_action_r;
      CMD_ALERT_MASK:  rd_data_nxt[3:0] = mask_r;
      CMD_STATUS_BYTE: rd_data_nxt[7:0] = stat_byte;
      CMD_STATUS_WORD: begin
        rd_data_nxt[7:0]     = stat_byte;
        rd_data_nxt[SW_IOUT] = oc_flt_r[page_r]; // RULE1
        rd_data_nxt[SW_MFR]  = ot_flt_r; // RULE11
      end
      CMD_STATUS_IOUT: rd_data_nxt[SIOUT_OC] = oc_flt_r[page_r]; // RULE1
      CMD_STATUS_MFR:  rd_data_nxt[SMFR_OT] = ot_flt_r; // RULE11
      CMD_STATUS_CML:  rd_data_nxt[SCML_DATA] = cml_r;
      default:         rd_data_nxt = 16'h0000;
    endcase
    out_en_nxt  = ot_block ? 2'b00 : chan_on; // RULE13 RULE14
    alert_n_nxt = !((oc_flt_r[0] && !mask_r[0]) || (oc_flt_r[1] && !mask_r[1]) ||
                    (ot_flt_r && !mask_r[MASK_OT]) || (cml_r && !mask_r[MASK_CML])); // RULE2 RULE11
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_valid_out      <= 1'b0;
      rd_data_out       <= 16'h0000;
      output_enable_out <= 2'b00;
      current_limit_out <= 2'b00;
      alert_n_out       <= 1'b1;
    end else begin
      rd_valid_out      <= rd_valid_nxt;
      rd_data_out       <= rd_data_nxt;
      output_enable_out <= out_en_nxt;
      current_limit_out <= chan_lim & ~{2{ot_block}}; // RULE13 RULE14
      alert_n_out       <= alert_n_nxt;
    end
  end

endmodule : ocf_fault_resp
`default_nettype wire

// ===== design/ocf_pkg.sv
`default_nettype none
package ocf_pkg;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE         = 8'h00;
  localparam logic [7:0] CMD_OPERATION    = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_RESTORE_ALL  = 8'h16;
  localparam logic [7:0] CMD_OC_ACTION    = 8'h47;
  localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
  localparam logic [7:0] CMD_STATUS_IOUT  = 8'h7B;
  localparam logic [7:0] CMD_STATUS_CML   = 8'h7E;
  localparam logic [7:0] CMD_STATUS_MFR   = 8'h80;
  localparam logic [7:0] CMD_OT_ACTION    = 8'hD6;
  localparam logic [7:0] CMD_ALERT_MASK   = 8'hE0;
  localparam logic [7:0] CMD_SOFT_RESET   = 8'hFD;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] OC_ACTION_RST  = 8'h00;
  localparam logic [7:0] OT_ACTION_RST  = 8'hC0;
  localparam logic       OPERATION_RST  = 1'b1;
  localparam logic [3:0] ALERT_MASK_RST = 4'h0;

  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB   = 2;
  localparam int DLY_LSB   = 0;
  localparam int OP_ON     = 7;
  localparam logic [1:0] RESP_CC      = 2'b00;
  localparam logic [1:0] RESP_BAD     = 2'b01;
  localparam logic [1:0] RESP_DELAY   = 2'b10;
  localparam logic [1:0] RESP_SHUT    = 2'b11;
  localparam logic [1:0] OT_RESP_LAT  = 2'b10;
  localparam logic [1:0] OT_RESP_AUTO = 2'b11;
  localparam logic [2:0] RETRY_NONE   = 3'b000;
  localparam logic [2:0] RETRY_FOREVER = 3'b111;
  localparam int SB_NONE    = 0;
  localparam int SB_CML     = 1;
  localparam int SB_IOUT_OC = 4;
  localparam int SW_MFR     = 12;
  localparam int SW_IOUT    = 14;
  localparam int SIOUT_OC   = 7;
  localparam int SMFR_OT    = 6;
  localparam int SCML_DATA  = 6;
  localparam int MASK_OT    = 2;
  localparam int MASK_CML   = 3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_TIME_US  = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int OC_UNIT_MS    = 16;
  localparam int RETRY_TIME_MS = 100;

  typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_LIMIT, ST_RETRY, ST_LATCH} ocf_state_t;

  // State entered once a fault has forced the output off
  function automatic ocf_state_t ocf_after_fault(input logic [2:0] retry);
    ocf_after_fault = (retry == RETRY_FOREVER) ? ST_RETRY : ST_LATCH;
  endfunction : ocf_after_fault

endpackage : ocf_pkg
`default_nettype wire

// ===== design/ocf_chan.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_chan
  import ocf_pkg::*;
#(
  parameter int RETRY_TICKS = RETRY_TIME_MS
) (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       tick_in,
  input  wire logic       enable_in,
  input  wire logic       oc_det_in,
  input  wire logic [7:0] action_in,
  output logic            output_on_out,
  output logic            limiting_out,
  output logic            oc_event_out
);

  ocf_state_t  state_r;
  ocf_state_t  state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [1:0]  resp;
  logic [2:0]  retry;
  logic [2:0]  dly;

  assign resp  = action_in[RESP_MSB:RESP_LSB];
  assign retry = action_in[RETRY_MSB:RETRY_LSB];
  assign dly   = action_in[DLY_MSB:DLY_LSB];

  // ------------------------------------------------------------
  // Response sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    oc_event_out  = 1'b0;
    limiting_out  = 1'b0;
    output_on_out = (state_r == ST_RUN) || (state_r == ST_LIMIT);
    case (state_r)
      ST_OFF: begin
        if (enable_in) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_in) begin
          state_nxt = ST_OFF;
        end else if (oc_det_in) begin
          oc_event_out = 1'b1; // RULE1
          case (resp)
            RESP_DELAY: begin
              limiting_out = 1'b1;
              state_nxt    = ST_LIMIT; // RULE4
              cnt_nxt      = 16'(16'(dly) * 16'(OC_UNIT_MS)); // RULE8
            end
            RESP_SHUT: begin
              output_on_out = 1'b0;
              state_nxt     = ocf_after_fault(retry); // RULE5
              cnt_nxt       = 16'(RETRY_TICKS);
            end
            default: begin
              limiting_out = 1'b1; // RULE3
            end
          endcase
        end
      end
      ST_LIMIT: begin
        limiting_out = 1'b1;
        if (!enable_in) begin
          state_nxt = ST_OFF;
        end else if (!oc_det_in) begin
          state_nxt = ST_RUN;
        end else if (cnt_r == 16'h0000) begin
          state_nxt = ocf_after_fault(retry); // RULE4
          cnt_nxt   = 16'(RETRY_TICKS);
        end else if (tick_in) begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      ST_RETRY: begin
        if (!enable_in) begin
          state_nxt = ST_OFF; // RULE7
        end else if (cnt_r == 16'h0000) begin
          state_nxt = ST_RUN; // RULE7
        end else if (tick_in) begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      ST_LATCH: begin
        if (!enable_in) begin
          state_nxt = ST_OFF; // RULE6
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= ST_OFF;
      cnt_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule : ocf_chan
`default_nettype wire

// ===== dv/ocf_fault_resp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_fault_resp_checker
  import ocf_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_write_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [7:0]  cmd_data_in,
  input wire logic [1:0]  run_in,
  input wire logic [1:0]  oc_detect_in,
  input wire logic        ot_detect_in,
  input wire logic        rd_valid_out,
  input wire logic [15:0] rd_data_out,
  input wire logic [1:0]  output_enable_out,
  input wire logic [1:0]  current_limit_out,
  input wire logic        alert_n_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // ----
  // Shadow state
  // ----
  logic       wr, rd, pg_r, pg_nxt, stale_r, stale_nxt;
  logic [3:0] calm_r, calm_nxt;
  logic [7:0] ot_r, ot_nxt;
  logic [7:0] oc_r   [2];
  logic [7:0] oc_nxt [2];
  always_comb begin
    wr        = cmd_valid_in && cmd_write_in;
    rd        = cmd_valid_in && !cmd_write_in;
    pg_nxt    = pg_r;
    stale_nxt = stale_r;
    ot_nxt    = ot_r;
    oc_nxt    = oc_r;
    calm_nxt  = (calm_r == 4'hf) ? calm_r : calm_r + 4'h1;
    if ((|oc_detect_in) || ot_detect_in || !(&run_in) || cmd_valid_in) calm_nxt = 4'h0;
    if (wr && cmd_code_in == CMD_PAGE) pg_nxt = cmd_data_in[0];
    if (wr && cmd_code_in == CMD_OC_ACTION && cmd_data_in[7:6] != RESP_BAD) oc_nxt[pg_r] = cmd_data_in;
    if (wr && cmd_code_in == CMD_OT_ACTION && cmd_data_in[7] && cmd_data_in[5:3] == RETRY_NONE) ot_nxt = cmd_data_in;
    if (wr && (cmd_code_in == CMD_RESTORE_ALL || cmd_code_in == CMD_SOFT_RESET)) stale_nxt = 1'b1;
    if (rst_in) begin
      pg_nxt    = 1'b0;
      stale_nxt = 1'b0;
      calm_nxt  = 4'h0;
      ot_nxt    = OT_ACTION_RST;
      oc_nxt    = '{OC_ACTION_RST, OC_ACTION_RST};
    end
  end
  always_ff @(posedge clock_in) begin
    pg_r    <= pg_nxt;
    stale_r <= stale_nxt;
    calm_r  <= calm_nxt;
    ot_r    <= ot_nxt;
    oc_r    <= oc_nxt;
  end
  // ----
  // Assertions
  // ----
  chk_read_answer:
    assert property (rd |=> rd_valid_out)
    else $error("read answer missing");
  chk_reset_quiet:
    assert property (disable iff (1'b0) rst_in |=> !rd_valid_out && alert_n_out && output_enable_out == 2'b00)
    else $error("outputs active after reset");
  chk_ot_value:
    assert property (rd && cmd_code_in == CMD_OT_ACTION && !stale_r |=> rd_data_out[7:0] == ot_r)
    else $error("overtemperature action value wrong");
  chk_oc_value:
    assert property (rd && cmd_code_in == CMD_OC_ACTION && !stale_r |=> rd_data_out[7:0] == oc_r[pg_r])
    else $error("overcurrent action value wrong");
  chk_ot_forces_off:
    assert property (ot_detect_in [*6] |-> output_enable_out == 2'b00)
    else $error("output on during overtemperature");
  chk_limit_runs:
    assert property ((current_limit_out & ~output_enable_out) == 2'b00)
    else $error("limiting while output off");
  chk_limit_cause0:
    assert property ($rose(current_limit_out[0]) |-> $past(oc_detect_in[0], 3))
    else $error("channel 0 limits without overcurrent");
  chk_limit_cause1:
    assert property ($rose(current_limit_out[1]) |-> $past(oc_detect_in[1], 3))
    else $error("channel 1 limits without overcurrent");
  chk_off_cause:
    assert property ($fell(output_enable_out[0]) || $fell(output_enable_out[1]) |-> calm_r <= 4'h6)
    else $error("output dropped without cause");
  chk_on_needs_run:
    assert property ($rose(output_enable_out[0]) |-> $past(run_in[0], 4))
    else $error("output on without run");
endmodule : ocf_fault_resp_checker
`default_nettype wire

// ===== dv/ocf_host.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_host
  import ocf_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rd_valid_in,
  input  wire logic [15:0] rd_data_in,
  output logic             cmd_valid_out,
  output logic             cmd_write_out,
  output logic [7:0]       cmd_code_out,
  output logic [7:0]       cmd_data_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out  = 8'h00;
    cmd_data_out  = 8'h00;
  end
  // One command; lines scrambled once released
  task automatic send(input logic w, input logic [7:0] code, input logic [7:0] data, output logic [15:0] ans);
    @(negedge clock_in);
    cmd_valid_out = 1'b1;
    cmd_write_out = w;
    cmd_code_out  = code;
    cmd_data_out  = data;
    @(negedge clock_in);
    ans           = rd_valid_in ? rd_data_in : 16'hxxxx;
    cmd_valid_out = 1'b0;
    cmd_code_out  = ~code;
    cmd_data_out  = ~data;
  endtask : send
endmodule : ocf_host
`default_nettype wire

// ===== dv/ocf_fault_resp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_fault_resp_tb
  import ocf_pkg::*;
;
  logic        clock_in, rst_in, cmd_valid, cmd_write, rd_valid, alert_n, ot;
  logic [7:0]  cmd_code, cmd_data;
  logic [1:0]  run, oc, oe, lim;
  logic [15:0] rd_data;
  logic [7:0]  clr [3];
  int          fails, n_checks;

  ocf_fault_resp #(.TICK_PERIOD(4), .RETRY_TICKS(3)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .run_in(run), .oc_detect_in(oc),
    .ot_detect_in(ot), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .output_enable_out(oe), .current_limit_out(lim), .alert_n_out(alert_n));
  ocf_host host (
    .clock_in(clock_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data), .cmd_valid_out(cmd_valid),
    .cmd_write_out(cmd_write), .cmd_code_out(cmd_code), .cmd_data_out(cmd_data));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    logic [15:0] unused;
    host.send(1'b1, code, data, unused);
  endtask : wr
  task automatic rdc(input string name, input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] got;
    host.send(1'b0, code, 8'h00, got);
    chk(name, exp, got);
  endtask : rdc
  task automatic pins(input logic [4:0] exp);
    chk("pins", {11'h000, exp}, {11'h000, oe, lim, alert_n});
  endtask : pins
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // ----
  // Tests
  // ----
  initial begin
    rst_in = 1'b1;
    run    = 2'b11;
    oc     = 2'b00;
    ot     = 1'b0;
    clr    = '{CMD_CLEAR_FAULTS, CMD_RESTORE_ALL, CMD_SOFT_RESET};
    cyc(8);
    rst_in = 1'b0;
    cyc(6);
    pins(5'b11_00_1);
    rdc("oc action", CMD_OC_ACTION, 16'h0000);
    rdc("ot action", CMD_OT_ACTION, 16'h00c0);
    oc = 2'b01;
    cyc(6);
    pins(5'b11_01_0);
    rdc("status byte", CMD_STATUS_BYTE, 16'h0011);
    rdc("status word", CMD_STATUS_WORD, 16'h4011);
    rdc("status iout", CMD_STATUS_IOUT, 16'h0080);
    oc = 2'b00;
    cyc(4);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    rdc("iout cleared", CMD_STATUS_IOUT, 16'h0000);
    wr(CMD_ALERT_MASK, 8'h01);
    oc = 2'b01;
    cyc(6);
    pins(5'b11_01_1);
    oc = 2'b00;
    cyc(4);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    wr(CMD_ALERT_MASK, 8'h00);
    wr(CMD_OC_ACTION, 8'h40);
    rdc("oc action", CMD_OC_ACTION, 16'h0000);
    rdc("cml", CMD_STATUS_CML, 16'h0040);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    wr(CMD_PAGE, 8'h01);
    wr(CMD_OC_ACTION, 8'hc0);
    rdc("oc action", CMD_OC_ACTION, 16'h00c0);
    wr(CMD_PAGE, 8'h00);
    rdc("oc action", CMD_OC_ACTION, 16'h0000);
    oc = 2'b10;
    cyc(6);
    pins(5'b01_00_0);
    oc = 2'b00;
    cyc(20);
    pins(5'b01_00_0);
    run = 2'b01;
    cyc(6);
    run = 2'b11;
    cyc(6);
    pins(5'b11_00_1);
    wr(CMD_OC_ACTION, 8'hf8);
    oc = 2'b01;
    cyc(6);
    pins(5'b10_00_0);
    oc = 2'b00;
    for (int i = 0; i < 60 && oe[0] !== 1'b1; i++) cyc(1);
    chk("restart", 16'h0001, {15'h0000, oe[0]});
    wr(CMD_CLEAR_FAULTS, 8'h00);
    wr(CMD_OC_ACTION, 8'h81);
    oc = 2'b01;
    cyc(40);
    pins(5'b11_01_0);
    cyc(60);
    pins(5'b10_00_0);
    oc  = 2'b00;
    run = 2'b10;
    cyc(6);
    run = 2'b11;
    cyc(6);
    pins(5'b11_00_1);
    for (int r = 1; r < 8; r++) wr(CMD_OT_ACTION, {2'b11, r[2:0], 3'b000});
    wr(CMD_OT_ACTION, 8'h00);
    wr(CMD_OT_ACTION, 8'h40);
    rdc("ot action", CMD_OT_ACTION, 16'h00c0);
    rdc("cml", CMD_STATUS_CML, 16'h0040);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    wr(CMD_OT_ACTION, 8'h87);
    rdc("ot action", CMD_OT_ACTION, 16'h0087);
    ot = 1'b1;
    cyc(6);
    pins(5'b00_00_0);
    rdc("status word", CMD_STATUS_WORD, 16'h1001);
    rdc("status mfr", CMD_STATUS_MFR, 16'h0040);
    ot = 1'b0;
    cyc(10);
    pins(5'b00_00_0);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    cyc(6);
    pins(5'b11_00_1);
    wr(CMD_OT_ACTION, 8'hc0);
    ot = 1'b1;
    cyc(6);
    pins(5'b00_00_0);
    ot = 1'b0;
    cyc(6);
    pins(5'b11_00_0);
    wr(CMD_OC_ACTION, 8'h00);
    foreach (clr[k]) begin
      oc = 2'b01;
      cyc(6);
      oc = 2'b00;
      cyc(6);
      rdc("iout latched", CMD_STATUS_IOUT, 16'h0080);
      wr(clr[k], 8'h00);
      rdc("iout cleared", CMD_STATUS_IOUT, 16'h0000);
    end
    oc = 2'b01;
    cyc(6);
    oc = 2'b00;
    wr(CMD_OPERATION, 8'h00);
    cyc(6);
    pins(5'b10_00_0);
    rdc("operation", CMD_OPERATION, 16'h0000);
    wr(CMD_OPERATION, 8'h80);
    cyc(6);
    pins(5'b11_00_1);
    results();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge clock_in);
    fails++;
    results();
  end
endmodule : ocf_fault_resp_tb

bind ocf_fault_resp ocf_fault_resp_checker u_chk (
  .clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
  .cmd_code_in(cmd_code_in), .cmd_data_in(cmd_data_in), .run_in(run_in), .oc_detect_in(oc_detect_in),
  .ot_detect_in(ot_detect_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
  .output_enable_out(output_enable_out), .current_limit_out(current_limit_out), .alert_n_out(alert_n_out));
`default_nettype wire
